// [logic/mederr_params.svh]
// Offsets, field positions and reset values of the math error detector.
`ifndef MEDERR_PARAMS_SVH
`define MEDERR_PARAMS_SVH

// Register byte offsets on the plain register port.
`define MEDERR_CTRL_OFS 4'h0
`define MEDERR_STAT_OFS 4'h4
`define MEDERR_INT_STATUS_OFS 4'h8
`define MEDERR_INT_MASK_OFS 4'hc

// Field positions in the control register.
`define MEDERR_CTRL_SEL_LSB 0
`define MEDERR_CTRL_SEL_MSB 1
`define MEDERR_CTRL_AUTO_BIT 2
`define MEDERR_CTRL_REF_BIT 3

// Field positions in the status register.
`define MEDERR_STAT_FLAG_BIT 0
`define MEDERR_STAT_ZD_BIT 1
`define MEDERR_STAT_OV_BIT 2

// Interrupt event bits, shared by status and mask.
`define MEDERR_INT_FLAG_BIT 0
`define MEDERR_INT_ZD_BIT 1
`define MEDERR_INT_OV_BIT 2
`define MEDERR_INT_W 3

// Reset values.
`define MEDERR_CTRL_RST 4'h3
`define MEDERR_INT_MASK_RST 3'h0

`endif

// [logic/mederr_pkg.sv]
// Types shared by the math error detector and its users.
package mederr_pkg;

	// Error selection; the code doubles as a mask over {overflow, zero division}.
	typedef enum logic [1:0] {
		MEDERR_SEL_NONE = 2'h0,
		MEDERR_SEL_ZERO_DIV = 2'h1,
		MEDERR_SEL_OVERFLOW = 2'h2,
		MEDERR_SEL_EITHER = 2'h3
	} mederr_sel_e;

	// Status bits left by the watched math block at the end of an execution.
	typedef struct packed {
		logic overflow_status_bit;
		logic zero_div_status_bit;
	} mederr_math_status_s;

endpackage

// [logic/mederr_detector.sv]
// Math error detector: scan-evaluated error flag with register port and interrupt.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "mederr_params.svh"

// How the block sits in a design: the watched math block pulses math_done with its two
// status bits at the end of every execution, and the scan logic pulses scan_eval at the
// point in the scan where this detector is evaluated. Software sets the selection, the
// clearing mode and whether a block is referenced through the register port, and reads
// back the flag and the held status bits there as well.
//
// Every input is expected from logic on ref_clk, so none of them is synchronised; a pin
// routed straight in would need its own two-flop stage in front of this block.
//
// The flag, the interrupt line and the read data are all registered, so downstream
// logic sees each result one clock after the edge that caused it.

module mederr_detector #(
	parameter int ADDR_W = 4
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic math_done,
	input wire mederr_pkg::mederr_math_status_s math_status,
	input wire logic scan_eval,
	input wire logic enable,
	input wire logic flag_reset,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic err_flag,
	output logic irq
);
	import mederr_pkg::*;

	// The decoder compares full 4-bit offsets, so a narrower port cannot reach them.
	if (ADDR_W < 4) begin : g_bad_addr_w
		$error("mederr_detector: ADDR_W must be at least 4");
	end

	// Returns the error seen through the selection mask.
	function automatic logic detect(input mederr_sel_e sel, input mederr_math_status_s st);
		detect = (sel[0] & st.zero_div_status_bit) | (sel[1] & st.overflow_status_bit);
	endfunction

	// Returns the register offset addressed, held to four bits.
	function automatic logic [3:0] offset_of(input logic [ADDR_W-1:0] a);
		offset_of = a[3:0];
	endfunction

	mederr_sel_e ctrl_sel; // Which error the flag watches.
	logic ctrl_auto; // Automatic clearing before each evaluation.
	logic ctrl_ref; // A math block is referenced.
	mederr_math_status_s held_status; // Bits from the latest math execution.
	mederr_math_status_s cur_status; // Bits the evaluation looks at.
	logic eval_now; // This cycle is an enabled evaluation.
	logic err_now; // Selected error present at this evaluation.
	logic [`MEDERR_INT_W-1:0] int_status; // Sticky interrupt events.
	logic [`MEDERR_INT_W-1:0] int_mask; // Interrupt enables.
	logic [`MEDERR_INT_W-1:0] int_event; // Events raised this cycle.
	logic [`MEDERR_INT_W-1:0] next_int_status; // Sticky bits after this cycle.
	logic next_flag; // Flag value for the next cycle.

	// An evaluation only counts while enabled; otherwise nothing is sampled.
	assign eval_now = scan_eval & enable;

	// A math execution finishing in the evaluation cycle counts as earlier in the scan,
	// and the bypass costs one multiplexer but saves a whole scan of latency,
	// so its fresh bits are used directly; a later one is caught by the next scan.
	assign cur_status = math_done ? math_status : held_status;

	// The selection code doubles as a mask, so one function serves every mode.
	// Unreferenced detector never sees an error.
	assign err_now = ctrl_ref & detect(ctrl_sel, cur_status);

	// Capture the math block's status bits at the end of each of its executions. The bits are
	// kept even while the detector is disabled, because they belong to the math block and the
	// next enabled evaluation must see its most recent execution.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			held_status <= '0;
		end else if (math_done) begin
			held_status <= math_status;
		end
	end

	// Flag update. An unreferenced detector is forced low at once. In auto-clear mode an
	// evaluation replaces the flag with the current error, so a stale error never lingers.
	// In held mode an error raised at an evaluation beats a reset arriving together, which
	// keeps a fault seen in the same cycle as a late reset from being lost.
	always_comb begin
		next_flag = err_flag;
		if (!ctrl_ref) begin
			next_flag = 1'b0;
		end else if (eval_now && ctrl_auto) begin
			next_flag = err_now;
		end else if (eval_now && err_now) begin
			next_flag = 1'b1;
		end else if (flag_reset) begin
			next_flag = 1'b0;
		end
	end

	// The flag register itself, driving the output directly.
	// Keeping the output on a flip-flop means downstream logic never sees a combinational glitch.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			err_flag <= 1'b0;
		end else begin
			err_flag <= next_flag;
		end
	end

	// Interrupt events: flag rising, and each error kind seen at an evaluation.
	// The error kinds are reported whatever the selection is, so software can see faults
	// that the flag is set to ignore.
	assign int_event[`MEDERR_INT_FLAG_BIT] = next_flag & ~err_flag;
	assign int_event[`MEDERR_INT_ZD_BIT] = eval_now & ctrl_ref & cur_status.zero_div_status_bit;
	assign int_event[`MEDERR_INT_OV_BIT] = eval_now & ctrl_ref & cur_status.overflow_status_bit;

	// Write-one-to-clear, but an event in the same cycle keeps its bit set, so software
	// never loses an event that arrives while it is clearing the older ones.
	always_comb begin
		next_int_status = int_status;
		if (reg_wr && offset_of(reg_addr) == `MEDERR_INT_STATUS_OFS) begin
			next_int_status = int_status & ~reg_wdata[`MEDERR_INT_W-1:0];
		end
		next_int_status = next_int_status | int_event;
	end

	// Sticky interrupt status register.
	// It is cleared only by reset or by software, never by the flag falling.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			int_status <= '0;
		end else begin
			int_status <= next_int_status;
		end
	end

	// Interrupt line from the values the status and mask take this edge,
	// so it tracks them with no extra cycle of lag. A mask write uses the new mask
	// straight from the write data, since the mask register itself only changes at this edge.
	// The cost is one more small AND term in front of the flip-flop.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else if (reg_wr && offset_of(reg_addr) == `MEDERR_INT_MASK_OFS) begin
			irq <= |(next_int_status & reg_wdata[`MEDERR_INT_W-1:0]);
		end else begin
			irq <= |(next_int_status & int_mask);
		end
	end

	// Control and mask registers written by software. A change of selection or mode takes
	// effect from the next evaluation on; the flag keeps its value until then, except that
	// clearing the referenced bit forces it low straight away.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_sel <= mederr_sel_e'(2'(`MEDERR_CTRL_RST));
			ctrl_auto <= 1'(`MEDERR_CTRL_RST >> `MEDERR_CTRL_AUTO_BIT);
			ctrl_ref <= 1'(`MEDERR_CTRL_RST >> `MEDERR_CTRL_REF_BIT);
			int_mask <= `MEDERR_INT_MASK_RST;
		end else if (reg_wr) begin
			case (offset_of(reg_addr))
				`MEDERR_CTRL_OFS: begin
					ctrl_sel <= mederr_sel_e'(reg_wdata[`MEDERR_CTRL_SEL_MSB:`MEDERR_CTRL_SEL_LSB]);
					ctrl_auto <= reg_wdata[`MEDERR_CTRL_AUTO_BIT];
					ctrl_ref <= reg_wdata[`MEDERR_CTRL_REF_BIT];
				end
				`MEDERR_INT_MASK_OFS: begin
					int_mask <= reg_wdata[`MEDERR_INT_W-1:0];
				end
				default: begin
					// Other offsets hold no bits written here; interrupt status bits are cleared in their own block.
				end
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe; unmapped offsets read zero.
	// Returning zero outside read cycles lets a master OR several slaves' data together
	// without any further gating.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= '0;
			case (offset_of(reg_addr))
				`MEDERR_CTRL_OFS: begin
					reg_rdata[`MEDERR_CTRL_SEL_MSB:`MEDERR_CTRL_SEL_LSB] <= ctrl_sel;
					reg_rdata[`MEDERR_CTRL_AUTO_BIT] <= ctrl_auto;
					reg_rdata[`MEDERR_CTRL_REF_BIT] <= ctrl_ref;
				end
				`MEDERR_STAT_OFS: begin
					reg_rdata[`MEDERR_STAT_FLAG_BIT] <= err_flag;
					reg_rdata[`MEDERR_STAT_ZD_BIT] <= held_status.zero_div_status_bit;
					reg_rdata[`MEDERR_STAT_OV_BIT] <= held_status.overflow_status_bit;
				end
				`MEDERR_INT_STATUS_OFS: begin
					reg_rdata[`MEDERR_INT_W-1:0] <= int_status;
				end
				`MEDERR_INT_MASK_OFS: begin
					reg_rdata[`MEDERR_INT_W-1:0] <= int_mask;
				end
				default: begin
					// Unmapped offset answers zero.
				end
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// Checks on the flag, the interrupt path and the register port. Every one of them runs
	// on the single clock, so the clock and the reset are named once for the whole module.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	// With no math block referenced the flag is low from the next cycle on.
	chk_unref_low: assert property (!ctrl_ref |=> !err_flag)
		else $error("flag high with no referenced block");

	// A cycle with neither an evaluation nor a reset leaves the flag where it was.
	chk_disabled_hold: assert property (
		(!eval_now && !flag_reset && ctrl_ref) ##1 ctrl_ref |-> $stable(err_flag))
		else $error("flag changed without evaluation");

	// An evaluation point that arrives while disabled must not move the flag either.
	chk_enable_low: assert property (
		scan_eval && !enable && !flag_reset && ctrl_ref |=> $stable(err_flag))
		else $error("flag changed while the detector was disabled");

	// In auto-clear mode each evaluation sets the flag to exactly the error it sees.
	chk_auto_follow: assert property (
		eval_now && ctrl_ref && ctrl_auto |=> err_flag == $past(err_now))
		else $error("auto-clear flag does not follow current error");

	// In held mode an error seen at an evaluation raises the flag, even against a reset.
	chk_sticky_set: assert property (
		eval_now && ctrl_ref && !ctrl_auto && err_now |=> err_flag)
		else $error("held flag not raised by an error");

	// Once raised in held mode, the flag survives quiet cycles until the reset input.
	chk_sticky_hold: assert property (
		eval_now && ctrl_ref && !ctrl_auto && err_now ##1 (!flag_reset && !eval_now && ctrl_ref) [*3]
		|-> err_flag)
		else $error("held flag dropped without reset");

	// The reset input clears the flag whenever no evaluation competes with it.
	chk_reset_clears: assert property (
		flag_reset && !eval_now |=> !err_flag)
		else $error("reset input did not clear flag");

	// Zero-division mode looks at the zero-division bit alone.
	chk_zero_div_only: assert property (
		eval_now && ctrl_ref && ctrl_auto && ctrl_sel == MEDERR_SEL_ZERO_DIV
		|=> err_flag == $past(cur_status.zero_div_status_bit))
		else $error("zero-division mode flag wrong");

	// Overflow mode looks at the overflow bit alone.
	chk_overflow_only: assert property (
		eval_now && ctrl_ref && ctrl_auto && ctrl_sel == MEDERR_SEL_OVERFLOW
		|=> err_flag == $past(cur_status.overflow_status_bit))
		else $error("overflow mode flag wrong");

	// Either mode raises the flag on any of the two bits.
	chk_either_or: assert property (
		eval_now && ctrl_ref && ctrl_auto && ctrl_sel == MEDERR_SEL_EITHER
		|=> err_flag == ($past(cur_status.zero_div_status_bit) | $past(cur_status.overflow_status_bit)))
		else $error("either mode flag is not the OR of both bits");

	// A math execution ending in the evaluation cycle is reported by that evaluation.
	chk_same_scan: assert property (
		math_done && eval_now && ctrl_ref && ctrl_sel == MEDERR_SEL_EITHER
		&& (math_status.zero_div_status_bit || math_status.overflow_status_bit) |=> err_flag)
		else $error("error from earlier execution not reported in same scan");

	// A math execution ending between evaluations is reported by the next one.
	chk_next_scan: assert property (
		math_done && !scan_eval && ctrl_ref && ctrl_sel == MEDERR_SEL_ZERO_DIV
		&& math_status.zero_div_status_bit ##1 (!math_done && eval_now && ctrl_ref) |=> err_flag)
		else $error("error from later execution not reported next scan");

	// The status bits are taken at the end of every execution and kept until the next.
	chk_status_capture: assert property (math_done |=> held_status == $past(math_status))
		else $error("status bits of a finished execution not captured");

	// Between executions the held bits do not move, whatever the status lines show.
	chk_status_keep: assert property (!math_done |=> $stable(held_status))
		else $error("held status bits changed without an execution");

	// A rising flag always leaves its mark in the sticky interrupt status.
	chk_flag_event: assert property (
		!err_flag ##1 err_flag |-> int_status[`MEDERR_INT_FLAG_BIT])
		else $error("flag rose without its interrupt event");

	// An event beats a write-one-to-clear that lands in the same cycle.
	chk_event_wins: assert property (
		|int_event |=> (int_status & $past(int_event)) == $past(int_event))
		else $error("interrupt event lost");

	// With no event raised in the same cycle, a write of ones clears exactly those status bits.
	chk_w1c_clear: assert property (
		reg_wr && offset_of(reg_addr) == `MEDERR_INT_STATUS_OFS && !(|int_event)
		|=> !(|(int_status & $past(reg_wdata[`MEDERR_INT_W-1:0]))))
		else $error("write of ones did not clear interrupt status");

	// The interrupt line follows the masked sticky status.
	chk_irq_level: assert property (
		##1 irq == |(int_status & int_mask))
		else $error("interrupt line disagrees with masked status");

	// The selection written into the control register reads back unchanged.
	chk_read_ctrl: assert property (
		reg_rd && offset_of(reg_addr) == `MEDERR_CTRL_OFS
		|=> reg_rdata[`MEDERR_CTRL_SEL_MSB:`MEDERR_CTRL_SEL_LSB] == $past(ctrl_sel))
		else $error("control read does not show the selection");

	// The status register shows the flag as it stood at the read strobe.
	chk_read_stat: assert property (
		reg_rd && offset_of(reg_addr) == `MEDERR_STAT_OFS
		|=> reg_rdata[`MEDERR_STAT_FLAG_BIT] == $past(err_flag))
		else $error("status read does not show the flag");

	// Read data stands for one cycle only and is zero the rest of the time.
	chk_read_once: assert property (
		!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data present without a read");

endmodule

// [testbench/mederr_math_model.sv]
// Behavioural model of the watched math block that feeds the detector.
`timescale 1ns/1ps
module mederr_math_model (
	input wire logic go,
	input wire logic zd,
	input wire logic ov,
	input wire logic neg,
	output logic math_done,
	output mederr_pkg::mederr_math_status_s math_status,
	output logic signed [15:0] math_result_value
);
	import mederr_pkg::*;
	// Status is only valid with the done pulse; between pulses the lines carry junk on purpose.
	always_comb begin
		math_done = go;
		math_status = go ? {ov, zd} : {~ov, ~zd};
	end
	// An error saturates the result to the end of the signed range.
	always_comb begin
		if (zd || (ov && !neg)) begin
			math_result_value = 16'sh7fff;
		end else if (ov) begin
			math_result_value = 16'sh8000;
		end else begin
			math_result_value = 16'sh0000;
		end
	end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the math error detector.
`timescale 1ns/1ps
`include "mederr_params.svh"
module testbench;
	import mederr_pkg::*;
	logic ref_clk = 1'b0, srst = 1'b1, go = 1'b0, zd = 1'b0, ov = 1'b0, neg = 1'b0;
	logic scan_eval = 1'b0, enable = 1'b0, flag_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, r;
	logic math_done, err_flag, irq;
	mederr_math_status_s math_status;
	logic signed [15:0] res;
	logic [31:0] rq[$]; // Expected read data, oldest first.
	logic fq[$]; // Expected flag after each evaluation or flag reset.
	logic [2:0] ist = 3'h0; // Expected pending interrupt events.
	logic [3:0] ctrl = 4'h3; // Shadow of the control register.
	logic ef = 1'b0, hz = 1'b0, ho = 1'b0, pf = 1'b0, pr = 1'b0, pe = 1'b0;
	int error_cnt = 0, cmp_count = 0, cyc = 0, seed = 15095;
	always #12.5 ref_clk = ~ref_clk;
	mederr_math_model mederr_math_model_inst (.go(go), .zd(zd), .ov(ov), .neg(neg), .math_done(math_done),
		.math_status(math_status), .math_result_value(res));
	mederr_detector mederr_detector_inst (.ref_clk(ref_clk), .srst(srst), .math_done(math_done),
		.math_status(math_status), .scan_eval(scan_eval), .enable(enable), .flag_reset(flag_reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .err_flag(err_flag), .irq(irq));
	// Word and bit compares; both count every call.
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({31'h0, got}, {31'h0, exp});
	endtask
	// One clock of stimulus; every input is driven so each strobe lasts exactly one cycle.
	task automatic drv(input logic w, rd, input logic [3:0] a, input logic [31:0] d, input logic g, z, o, e, en, fr);
		logic err;
		@(posedge ref_clk);
		reg_wr <= w;
		reg_rd <= rd;
		reg_addr <= a;
		reg_wdata <= d;
		go <= g;
		zd <= z;
		ov <= o;
		neg <= d[0];
		scan_eval <= e;
		enable <= en;
		flag_reset <= fr;
		if (g) begin
			hz = z;
			ho = o;
		end
		// Fresh status in the evaluation cycle is used at once, older status is held.
		err = e && en && ((ctrl[0] && hz) || (ctrl[1] && ho));
		pf = ef;
		if (!ctrl[3]) begin
			ef = 1'b0;
		end else if (ctrl[2]) begin
			ef = (e && en) ? err : (fr ? 1'b0 : ef);
		end else begin
			ef = (fr ? 1'b0 : ef) | err;
		end
		// Clear goes first so that a same-cycle event wins over the write of one.
		if (w && a == `MEDERR_INT_STATUS_OFS) ist = ist & ~d[2:0];
		if (e && en && ctrl[3]) ist = ist | {ho, hz, ef & ~pf};
		if (w && a == `MEDERR_CTRL_OFS) ctrl = d[3:0];
		if (e || fr) fq.push_back(ef);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		drv(1'b1, 1'b0, a, d, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] x);
		rq.push_back(x);
		drv(1'b0, 1'b1, a, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
	endtask
	// Results land one cycle after their cause, so they are compared at the falling edge.
	always @(negedge ref_clk) begin
		if (pr) begin
			cmp_word(reg_rdata, rq.pop_front());
		end else if (cyc > 0) begin
			cmp_word(reg_rdata, 32'h0);
		end
		if (pe) cmp_bit(err_flag, fq.pop_front());
		if (go && (zd || ov)) cmp_word({16'h0, res}, (zd || !neg) ? 32'h7fff : 32'h8000);
		pr = reg_rd;
		pe = scan_eval | flag_reset;
	end
	// Cuts a hang short; the run needs well under a thousand cycles.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		rd(`MEDERR_CTRL_OFS, 32'h3);
		rd(`MEDERR_INT_MASK_OFS, 32'h0);
		wr(4'h2, 32'hf);
		rd(4'h2, 32'h0);
		// Every control code: each selection, with and without auto clear, referenced or not.
		for (int c = 0; c < 16; c++) begin
			wr(`MEDERR_CTRL_OFS, c);
			drv(1'b0, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
			repeat (14) begin
				r = $random(seed);
				drv(1'b0, 1'b0, 4'h0, {31'h0, r[11]}, r[0], r[1], r[2], r[3] | r[4], |r[7:5],
					&r[10:8]);
			end
		end
		// Late and early math executions around the evaluation point, in held mode.
		wr(`MEDERR_CTRL_OFS, 32'h9);
		drv(1'b0, 1'b0, 4'h0, 32'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		drv(1'b0, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		wr(`MEDERR_CTRL_OFS, 32'hb);
		drv(1'b0, 1'b0, 4'h0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		drv(1'b0, 1'b0, 4'h0, 32'h1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		rd(`MEDERR_STAT_OFS, {29'h0, ho, hz, ef});
		#1 cmp_bit(irq, 1'b0);
		wr(`MEDERR_INT_MASK_OFS, 32'h7);
		rd(`MEDERR_INT_STATUS_OFS, {29'h0, ist});
		wr(4'h0, 32'hf);
		#1 cmp_bit(irq, |ist);
		wr(`MEDERR_INT_STATUS_OFS, {29'h0, ist});
		rd(`MEDERR_INT_STATUS_OFS, 32'h0);
		rd(4'h0, 32'hf);
		#1 cmp_bit(irq, 1'b0);
		repeat (2) @(posedge ref_clk);
		close_out();
	end
endmodule
